// File: logic/cpm_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_mode_ctrl (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exc_enter,
    input wire cpm_pkg::cpm_exc_t exc_info,
    input wire logic exc_return,
    input wire logic [8:0] ret_num,
    input wire logic cand_valid,
    input wire cpm_pkg::cpm_exc_t cand,
    output logic cand_allowed,
    input wire logic restricted_op,
    input wire cpm_pkg::cpm_gpr_req_t gpr_req,
    output logic [31:0] gpr_rdata,
    input wire logic call_en,
    input wire logic [31:0] call_ret_addr,
    input wire logic flags_we,
    input wire logic [4:0] flags_in,
    output logic [31:0] sp_value,
    output logic [31:0] fetch_addr,
    output logic handler_mode,
    output logic user_level,
    output logic psp_active,
    output logic fault_req,
    output logic irq
);
    // ==========================================================
    // state
    cpm_pkg::cpm_mode_t mode_q, mode_d;
    logic [1:0] ctrl_q;
    logic primary_interrupt_mask_q, fltmask_q;
    logic [8:0] base_priority_threshold_q, exception_number_status_q;
    logic [31:0] psw_q, msp_q, psp_q, lr_q, pc_q, rdata_q, grd_q;
    logic [2:0] evstat_q, evmask_q;
    logic [31:0] gpr_q [0:cpm_pkg::CPM_NUM_GPR-1];

    // ==========================================================
    // bus decode; zero wait states, read data caught in setup
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire a_psw = paddr == cpm_pkg::CPM_PSW_OFS;
    wire a_pm = paddr == cpm_pkg::CPM_PRIMARY_INTERRUPT_MASK_OFS;
    wire a_fm = paddr == cpm_pkg::CPM_FLTMASK_OFS;
    wire a_bp = paddr == cpm_pkg::CPM_BASE_PRIORITY_THRESHOLD_OFS;
    wire a_ctl = paddr == cpm_pkg::CPM_CTRL_OFS;
    wire a_msp = paddr == cpm_pkg::CPM_MSP_OFS;
    wire a_psp = paddr == cpm_pkg::CPM_PSP_OFS;
    wire a_lr = paddr == cpm_pkg::CPM_LR_OFS;
    wire a_pc = paddr == cpm_pkg::CPM_PC_OFS;
    wire a_evs = paddr == cpm_pkg::CPM_EVSTAT_OFS;
    wire a_evm = paddr == cpm_pkg::CPM_EVMASK_OFS;
    wire a_mode = paddr == cpm_pkg::CPM_MODE_OFS;
    wire mapped = a_psw | a_pm | a_fm | a_bp | a_ctl | a_msp | a_psp
        | a_lr | a_pc | a_evs | a_evm | a_mode;
    // user level only reaches the status word; the rest is refused
    wire blocked = user_level && !a_psw;
    wire tbit_clr = pwrite && a_psw && !pwdata[cpm_pkg::CPM_TBIT_POS];
    wire ok = access && mapped && !blocked;
    wire wr_en = ok && pwrite && !tbit_clr;
    wire priv_ev = (access && mapped && blocked)
        || (restricted_op && user_level);
    wire tbit_ev = access && mapped && !blocked && tbit_clr;

    assign pready = 1'b1;
    assign pslverr = access && (!mapped || blocked || tbit_clr);
    assign prdata = rdata_q;

    // ==========================================================
    // mode and stack selection
    assign handler_mode = mode_q == cpm_pkg::CPM_PRIV_HANDLER;
    assign user_level = mode_q == cpm_pkg::CPM_USER_THREAD;
    // handler never takes the alternate stack, whatever bit one holds
    assign psp_active = !handler_mode && ctrl_q[1];
    assign sp_value = psp_active ? psp_q : msp_q;
    assign fetch_addr = pc_q;

    wire [1:0] ctrl_d = (wr_en && a_ctl) ? pwdata[1:0] : ctrl_q;

    // three states only; handler is privileged by construction
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            cpm_pkg::CPM_PRIV_THREAD: begin
                if (exc_enter) begin
                    mode_d = cpm_pkg::CPM_PRIV_HANDLER;
                end else if (ctrl_d[0]) begin
                    mode_d = cpm_pkg::CPM_USER_THREAD;
                end
            end
            cpm_pkg::CPM_USER_THREAD: begin
                if (exc_enter) begin
                    mode_d = cpm_pkg::CPM_PRIV_HANDLER;
                end
            end
            cpm_pkg::CPM_PRIV_HANDLER: begin
                if (exc_return && ret_num == cpm_pkg::CPM_THREAD_NUM) begin
                    mode_d = ctrl_d[0] ? cpm_pkg::CPM_USER_THREAD
                        : cpm_pkg::CPM_PRIV_THREAD;
                end
            end
            default: mode_d = cpm_pkg::CPM_PRIV_THREAD;
        endcase
    end

    // mode and exception number
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode_q <= cpm_pkg::CPM_PRIV_THREAD;
            exception_number_status_q <= cpm_pkg::CPM_THREAD_NUM;
        end else begin
            mode_q <= mode_d;
            if (exc_enter) begin
                exception_number_status_q <= exc_info.num;
            end else if (exc_return) begin
                exception_number_status_q <= ret_num;
            end
        end
    end

    // ==========================================================
    // mask registers and control
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_q <= cpm_pkg::CPM_CTRL_RST;
            primary_interrupt_mask_q <= cpm_pkg::CPM_MASK_RST;
            fltmask_q <= cpm_pkg::CPM_MASK_RST;
            base_priority_threshold_q <= cpm_pkg::CPM_BASE_PRIORITY_THRESHOLD_RST;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_en && a_pm) primary_interrupt_mask_q <= pwdata[0];
            if (wr_en && a_fm) fltmask_q <= pwdata[0];
            if (wr_en && a_bp) base_priority_threshold_q <= pwdata[8:0];
        end
    end

    // nmi always passes; hard fault passes unless the fault mask is up
    wire is_nmi = cand.num == cpm_pkg::CPM_NMI_NUM;
    wire is_hf = cand.num == cpm_pkg::CPM_HARDFAULT_NUM;
    wire is_irq = cand.num >= cpm_pkg::CPM_FIRST_IRQ_NUM;
    wire bp_block = is_irq && base_priority_threshold_q != cpm_pkg::CPM_BASE_PRIORITY_THRESHOLD_RST
        && cand.pri >= base_priority_threshold_q;
    wire pm_block = primary_interrupt_mask_q && !is_hf;
    assign cand_allowed = cand_valid && (is_nmi
        || !(fltmask_q || pm_block || bp_block));

    // ==========================================================
    // status word; flags and execution state bits other than bit 24 are writable
    wire [31:0] flags_word = {flags_in, 27'h0} & cpm_pkg::CPM_FLAGS_MASK;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            psw_q <= cpm_pkg::CPM_PSW_RST;
        end else if (wr_en && a_psw) begin
            psw_q <= pwdata & cpm_pkg::CPM_PSW_RW_MASK;
        end else if (flags_we) begin
            psw_q <= (psw_q & ~cpm_pkg::CPM_FLAGS_MASK) | flags_word;
        end
    end
    // bit 24 forced high and exception number merged in on read
    wire [31:0] psw_view = (psw_q & cpm_pkg::CPM_PSW_RW_MASK)
        | (32'h1 << cpm_pkg::CPM_TBIT_POS) | {23'h0, exception_number_status_q};

    // ==========================================================
    // core register file: r0-r12, banked sp, lr, pc
    wire g_wr = gpr_req.valid && gpr_req.we;
    wire hi_bad = gpr_req.valid && gpr_req.is16
        && gpr_req.idx >= cpm_pkg::CPM_HI_FIRST
        && gpr_req.idx < cpm_pkg::CPM_SP_IDX;
    wire g_ok = g_wr && !hi_bad;
    wire sp_wr = g_ok && gpr_req.idx == cpm_pkg::CPM_SP_IDX;

    genvar gi;
    generate
        for (gi = 0; gi < cpm_pkg::CPM_NUM_GPR; gi++) begin : g_gpr
            // one 32-bit flop word per general register
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    gpr_q[gi] <= cpm_pkg::CPM_WORD_RST;
                end else if (g_ok && gpr_req.idx == 4'(gi)) begin
                    gpr_q[gi] <= gpr_req.wdata;
                end
            end
        end
    endgenerate

    // stack banks drop the low two bits so stacks stay word aligned
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            msp_q <= cpm_pkg::CPM_WORD_RST;
            psp_q <= cpm_pkg::CPM_WORD_RST;
        end else begin
            if (wr_en && a_msp) begin
                msp_q <= {pwdata[31:2], 2'b00};
            end else if (sp_wr && !psp_active) begin
                msp_q <= {gpr_req.wdata[31:2], 2'b00};
            end
            if (wr_en && a_psp) begin
                psp_q <= {pwdata[31:2], 2'b00};
            end else if (sp_wr && psp_active) begin
                psp_q <= {gpr_req.wdata[31:2], 2'b00};
            end
        end
    end

    // link register and program counter; a call beats a plain write
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lr_q <= cpm_pkg::CPM_WORD_RST;
            pc_q <= cpm_pkg::CPM_WORD_RST;
        end else begin
            if (call_en) begin
                lr_q <= call_ret_addr;
            end else if (wr_en && a_lr) begin
                lr_q <= pwdata;
            end else if (g_ok && gpr_req.idx == cpm_pkg::CPM_LR_IDX) begin
                lr_q <= gpr_req.wdata;
            end
            if (wr_en && a_pc) begin
                pc_q <= {pwdata[31:1], 1'b0};
            end else if (g_ok && gpr_req.idx == cpm_pkg::CPM_PC_IDX) begin
                pc_q <= {gpr_req.wdata[31:1], 1'b0};
            end
        end
    end

    // read port: one cycle after the request, refused reads give zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            grd_q <= cpm_pkg::CPM_WORD_RST;
        end else if (gpr_req.valid && !gpr_req.we) begin
            if (hi_bad) begin
                grd_q <= cpm_pkg::CPM_WORD_RST;
            end else if (gpr_req.idx == cpm_pkg::CPM_SP_IDX) begin
                grd_q <= sp_value;
            end else if (gpr_req.idx == cpm_pkg::CPM_LR_IDX) begin
                grd_q <= lr_q;
            end else if (gpr_req.idx == cpm_pkg::CPM_PC_IDX) begin
                grd_q <= pc_q;
            end else begin
                grd_q <= gpr_q[gpr_req.idx];
            end
        end
    end
    assign gpr_rdata = grd_q;

    // ==========================================================
    // events: sticky status, write one to clear, set beats clear
    wire [2:0] ev_set = {hi_bad, tbit_ev, priv_ev};
    wire [2:0] ev_clr = (wr_en && a_evs) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            evstat_q <= cpm_pkg::CPM_EV_RST;
            evmask_q <= cpm_pkg::CPM_EV_RST;
        end else begin
            evstat_q <= (evstat_q & ~ev_clr) | ev_set;
            if (wr_en && a_evm) evmask_q <= pwdata[2:0];
        end
    end
    assign irq = |(evstat_q & evmask_q);
    assign fault_req = priv_ev || tbit_ev;

    // ==========================================================
    // register read mux, sampled in the setup phase
    wire [31:0] rmux =
        a_psw ? psw_view :
        a_pm ? {31'h0, primary_interrupt_mask_q} :
        a_fm ? {31'h0, fltmask_q} :
        a_bp ? {23'h0, base_priority_threshold_q} :
        a_ctl ? {30'h0, ctrl_q} :
        a_msp ? msp_q :
        a_psp ? psp_q :
        a_lr ? lr_q :
        a_pc ? pc_q :
        a_evs ? {29'h0, evstat_q} :
        a_evm ? {29'h0, evmask_q} :
        a_mode ? {29'h0, psp_active, user_level, handler_mode} : 32'h0;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_q <= cpm_pkg::CPM_WORD_RST;
        end else if (setup) begin
            rdata_q <= (user_level && !a_psw) ? 32'h0 : rmux;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    user_handler_a: assert property (
        !(handler_mode && user_level))
        else $error("handler mode at user level");
    handler_entry_a: assert property (
        exc_enter |=> handler_mode && exception_number_status_q == $past(exc_info.num))
        else $error("exception entry missed handler mode");
    user_block_a: assert property (
        access && user_level && !a_psw && mapped
        |-> pslverr ##1 evstat_q[cpm_pkg::CPM_EV_PRIV])
        else $error("user access not refused");
    stack_bank_a: assert property (
        handler_mode |-> !psp_active && sp_value == msp_q)
        else $error("handler used process stack");
    sp_align_a: assert property (
        sp_wr && !exc_enter && !exc_return && !wr_en
        |=> sp_value == {$past(gpr_req.wdata[31:2]), 2'b00})
        else $error("stack pointer write misaligned");
    pc_align_a: assert property (
        g_ok && gpr_req.idx == cpm_pkg::CPM_PC_IDX && !wr_en
        |=> fetch_addr == {$past(gpr_req.wdata[31:1]), 1'b0})
        else $error("program counter bit zero set");
    hireg_block_a: assert property (
        hi_bad && gpr_req.we |=> $stable(gpr_q[8])
        && evstat_q[cpm_pkg::CPM_EV_HIREG])
        else $error("16-bit access reached a high register");
    call_link_a: assert property (
        call_en |=> lr_q == $past(call_ret_addr))
        else $error("link register not loaded on call");
    tbit_hold_a: assert property (
        tbit_ev && !flags_we
        |=> psw_view[cpm_pkg::CPM_TBIT_POS] && $stable(psw_q)
        && evstat_q[cpm_pkg::CPM_EV_TBIT])
        else $error("execution state bit cleared");
    primary_interrupt_mask_a: assert property (
        primary_interrupt_mask_q && !fltmask_q && cand_valid
        |-> cand_allowed == (is_nmi || is_hf))
        else $error("primary mask let an exception through");
    fault_level_mask_a: assert property (
        fltmask_q && cand_valid |-> cand_allowed == is_nmi)
        else $error("fault mask let an exception through");
    base_priority_threshold_a: assert property (
        cand_valid && is_irq && !primary_interrupt_mask_q && !fltmask_q
        |-> cand_allowed == (base_priority_threshold_q == 9'h000 || cand.pri < base_priority_threshold_q))
        else $error("base priority threshold wrong");
endmodule
`default_nettype wire

// File: inc/cpm_pkg.sv
package cpm_pkg;

    // ==========================================================
    // register offsets (byte addresses on the bus)
    localparam logic [11:0] CPM_PSW_OFS = 12'h000;
    localparam logic [11:0] CPM_PRIMARY_INTERRUPT_MASK_OFS = 12'h004;
    localparam logic [11:0] CPM_FLTMASK_OFS = 12'h008;
    localparam logic [11:0] CPM_BASE_PRIORITY_THRESHOLD_OFS = 12'h00C;
    localparam logic [11:0] CPM_CTRL_OFS = 12'h010;
    localparam logic [11:0] CPM_MSP_OFS = 12'h014;
    localparam logic [11:0] CPM_PSP_OFS = 12'h018;
    localparam logic [11:0] CPM_LR_OFS = 12'h01C;
    localparam logic [11:0] CPM_PC_OFS = 12'h020;
    localparam logic [11:0] CPM_EVSTAT_OFS = 12'h024;
    localparam logic [11:0] CPM_EVMASK_OFS = 12'h028;
    localparam logic [11:0] CPM_MODE_OFS = 12'h02C;

    // ==========================================================
    // status word layout
    localparam int CPM_TBIT_POS = 24;
    localparam logic [31:0] CPM_PSW_RW_MASK = 32'hFE00_FC00;
    localparam logic [31:0] CPM_FLAGS_MASK = 32'hF800_0000;
    localparam int CPM_FLAGS_LSB = 27;

    // ==========================================================
    // exception numbers and core register indices
    localparam logic [8:0] CPM_NMI_NUM = 9'h002;
    localparam logic [8:0] CPM_HARDFAULT_NUM = 9'h003;
    localparam logic [8:0] CPM_FIRST_IRQ_NUM = 9'h010;
    localparam logic [8:0] CPM_THREAD_NUM = 9'h000;
    localparam int CPM_NUM_GPR = 13;
    localparam logic [3:0] CPM_HI_FIRST = 4'h8;
    localparam logic [3:0] CPM_SP_IDX = 4'hD;
    localparam logic [3:0] CPM_LR_IDX = 4'hE;
    localparam logic [3:0] CPM_PC_IDX = 4'hF;

    // ==========================================================
    // event bits
    localparam int CPM_EV_PRIV = 0;
    localparam int CPM_EV_TBIT = 1;
    localparam int CPM_EV_HIREG = 2;
    localparam int CPM_EV_W = 3;

    // ==========================================================
    // reset values
    localparam logic [1:0] CPM_CTRL_RST = 2'h0;
    localparam logic CPM_MASK_RST = 1'b0;
    localparam logic [8:0] CPM_BASE_PRIORITY_THRESHOLD_RST = 9'h000;
    localparam logic [31:0] CPM_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] CPM_PSW_RST = 32'h0100_0000;
    localparam logic [2:0] CPM_EV_RST = 3'h0;

    typedef enum logic [1:0] {
        CPM_PRIV_THREAD,
        CPM_USER_THREAD,
        CPM_PRIV_HANDLER
    } cpm_mode_t;

    typedef struct packed {
        logic [8:0] num;
        logic [8:0] pri;
    } cpm_exc_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic is16;
        logic [3:0] idx;
        logic [31:0] wdata;
    } cpm_gpr_req_t;

endpackage

// File: tb/test_cpm_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpm_mode_ctrl;
    // ==========================================================
    // stimulus, observed outputs and reference state
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] call_ret_addr = 32'h0;
    logic [8:0] ret_num = 9'h000;
    logic [4:0] flags_in = 5'h00;
    logic [4:0] pv = 5'h00; // one-cycle strobes into the core side
    logic cand_valid = 1'h0;
    cpm_pkg::cpm_exc_t exc_info = '0;
    cpm_pkg::cpm_exc_t cand = '0;
    cpm_pkg::cpm_gpr_req_t gpr_req = '0;
    logic [31:0] prdata, gpr_rdata, sp_value, fetch_addr;
    logic pready, pslverr, cand_allowed, handler_mode;
    logic user_level, psp_active, fault_req, irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] rs = 32'h0000_69AE; // generator start value
    logic [31:0] rd, d, m_psw, m_msp, m_psp;
    logic [31:0] m_r [16];
    logic [8:0] m_bp = 9'h000;
    logic m_pm = 1'h0;
    logic m_fm = 1'h0;
    logic er, fq;

    // ==========================================================
    // clock and device under test
    always #4 ref_clk = ~ref_clk;

    cpm_mode_ctrl uut (
        .ref_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .exc_enter(pv[0]), .exc_info,
        .exc_return(pv[1]), .ret_num, .cand_valid, .cand, .cand_allowed,
        .restricted_op(pv[2]), .gpr_req, .gpr_rdata, .call_en(pv[3]),
        .call_ret_addr, .flags_we(pv[4]), .flags_in, .sp_value,
        .fetch_addr, .handler_mode, .user_level, .psp_active, .fault_req,
        .irq
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // reference masking decision; base priority only for numbered irqs
    function automatic logic [31:0] alw(logic [31:0] v);
        if (v[17:9] == cpm_pkg::CPM_NMI_NUM) return 32'h1;
        if (m_fm) return 32'h0;
        if (m_pm) return 32'(v[17:9] == cpm_pkg::CPM_HARDFAULT_NUM);
        if (m_bp != 9'h000 && v[17:9] >= cpm_pkg::CPM_FIRST_IRQ_NUM &&
            v[8:0] >= m_bp) return 32'h0;
        return 32'h1;
    endfunction

    function automatic logic [31:0] md();
        return {29'h0, handler_mode, user_level, psp_active};
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus transfer; answer taken at the rising edge where pready is seen
    // the hang guard alone ends a wait for a slave that never answers
    task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        fq = fault_req;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge ref_clk);
    endtask

    // core register port, one request, answer the cycle after
    task automatic gpr(logic we, logic s16, logic [3:0] ix, logic [31:0] v);
        @(posedge ref_clk);
        gpr_req <= '{1'h1, we, s16, ix, v};
        @(posedge ref_clk);
        gpr_req <= '0;
        @(negedge ref_clk);
        rd = gpr_rdata;
    endtask

    // single strobe k with its qualifiers taken from v
    task automatic pls(int k, logic [31:0] v);
        @(posedge ref_clk);
        pv <= 5'h01 << k;
        exc_info <= v[17:0];
        ret_num <= v[8:0];
        call_ret_addr <= v;
        flags_in <= v[4:0];
        @(negedge ref_clk);
        fq = fault_req;
        @(posedge ref_clk);
        pv <= 5'h00;
        @(negedge ref_clk);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // hang guard, well beyond the expected run length
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'h1;
        m_psw = cpm_pkg::CPM_PSW_RST;
        // reset contents of every register, then one unmapped word
        for (int a = 0; a <= 48; a += 4) begin
            apb(1'h0, a[11:0], 32'h0);
            chk("rst_rd", a == 0 ? m_psw : 32'h0, rd);
            chk("rst_err", 32'(a == 48), 32'(er));
        end
        chk("rst_mode", 32'h0, md());
        // low and high registers through wide and narrow encodings
        for (int i = 0; i < 13; i++) begin
            m_r[i] = xs();
            gpr(1'h1, 1'h0, i[3:0], m_r[i]);
            gpr(1'h1, 1'h1, i[3:0], ~m_r[i]);
            if (i < 8) m_r[i] = ~m_r[i];
            gpr(1'h0, 1'h1, i[3:0], 32'h0);
            chk("r_narrow", i < 8 ? m_r[i] : 32'h0, rd);
            gpr(1'h0, 1'h0, i[3:0], 32'h0);
            chk("r_wide", m_r[i], rd);
        end
        // refused access leaves an event; the interrupt rises only once unmasked
        apb(1'h0, cpm_pkg::CPM_EVSTAT_OFS, 32'h0);
        chk("ev_hi", 32'h4, rd);
        chk("irq_set", 32'h0, 32'(irq));
        apb(1'h1, cpm_pkg::CPM_EVMASK_OFS, 32'h7);
        chk("irq_mask", 32'h1, 32'(irq));
        apb(1'h1, cpm_pkg::CPM_EVSTAT_OFS, 32'h4);
        apb(1'h0, cpm_pkg::CPM_EVSTAT_OFS, 32'h0);
        chk("ev_clr", 32'h0, rd);
        chk("irq_clr", 32'h0, 32'(irq));
        apb(1'h1, cpm_pkg::CPM_EVMASK_OFS, 32'h0);
        // stack, program counter and link register
        m_msp = xs();
        gpr(1'h1, 1'h0, cpm_pkg::CPM_SP_IDX, m_msp);
        chk("sp", m_msp & 32'hFFFF_FFFC, sp_value);
        gpr(1'h0, 1'h0, cpm_pkg::CPM_SP_IDX, 32'h0);
        chk("sp_rd", m_msp & 32'hFFFF_FFFC, rd);
        d = xs();
        gpr(1'h1, 1'h0, cpm_pkg::CPM_PC_IDX, d);
        chk("pc", d & 32'hFFFF_FFFE, fetch_addr);
        d = xs();
        pls(3, d);
        gpr(1'h0, 1'h0, cpm_pkg::CPM_LR_IDX, 32'h0);
        chk("lr", d, rd);
        // status word: writable fields, flags, the fixed state bit
        d = xs() | 32'h0100_0000;
        apb(1'h1, cpm_pkg::CPM_PSW_OFS, d);
        m_psw = (m_psw & ~cpm_pkg::CPM_PSW_RW_MASK) |
                (d & cpm_pkg::CPM_PSW_RW_MASK);
        d = xs();
        pls(4, d);
        m_psw[31:27] = d[4:0];
        apb(1'h0, cpm_pkg::CPM_PSW_OFS, 32'h0);
        chk("psw", m_psw, rd);
        apb(1'h1, cpm_pkg::CPM_PSW_OFS, d & 32'hFEFF_FFFF);
        chk("t_err", 32'h3, {30'h0, er, fq});
        apb(1'h0, cpm_pkg::CPM_EVSTAT_OFS, 32'h0);
        chk("t_ev", 32'h2, rd);
        apb(1'h0, cpm_pkg::CPM_PSW_OFS, 32'h0);
        chk("psw_keep", m_psw, rd);
        apb(1'h1, cpm_pkg::CPM_EVSTAT_OFS, 32'h7);
        // entry, nested return, return to thread
        d = xs() | 32'h0001_0000;
        pls(0, d);
        m_psw[8:0] = d[17:9];
        chk("h_mode", 32'h4, md());
        apb(1'h0, cpm_pkg::CPM_PSW_OFS, 32'h0);
        chk("psw_exc", m_psw, rd);
        pls(1, 32'h5);
        m_psw[8:0] = 9'h005;
        chk("h_nest", 32'h4, md());
        apb(1'h0, cpm_pkg::CPM_PSW_OFS, 32'h0);
        chk("psw_nest", m_psw, rd);
        pls(1, 32'h0);
        chk("t_mode", 32'h0, md());
        // banked stack and a user level round trip
        m_psp = xs();
        apb(1'h1, cpm_pkg::CPM_PSP_OFS, m_psp);
        apb(1'h1, cpm_pkg::CPM_CTRL_OFS, 32'h2);
        chk("psp_on", 32'h1, md());
        chk("psp_sp", m_psp & 32'hFFFF_FFFC, sp_value);
        pls(0, xs() | 32'h0001_0000);
        chk("psp_exc", 32'h4, md());
        chk("msp_exc", m_msp & 32'hFFFF_FFFC, sp_value);
        apb(1'h1, cpm_pkg::CPM_CTRL_OFS, 32'h1); // select bit cleared to 0
        pls(2, 32'h0);
        chk("h_priv", 32'h4, md() | 32'(fq));
        pls(1, 32'h0);
        chk("user", 32'h2, md());
        pls(2, 32'h0);
        chk("u_fault", 32'h1, 32'(fq));
        apb(1'h1, cpm_pkg::CPM_PRIMARY_INTERRUPT_MASK_OFS, 32'h1);
        chk("u_blk", 32'h3, {30'h0, er, fq});
        apb(1'h0, cpm_pkg::CPM_PSW_OFS, 32'h0);
        chk("u_psw", 32'h0, 32'(er));
        pls(0, 32'h0001_0000);
        chk("u_exc", 32'h4, md());
        apb(1'h0, cpm_pkg::CPM_EVSTAT_OFS, 32'h0);
        chk("u_ev", 32'h1, rd);
        apb(1'h1, cpm_pkg::CPM_CTRL_OFS, 32'h0);
        pls(1, 32'h0);
        chk("priv", 32'h0, md());
        apb(1'h0, cpm_pkg::CPM_PRIMARY_INTERRUPT_MASK_OFS, 32'h0);
        chk("pm_keep", 32'h0, rd);
        // mask registers against candidate exceptions
        for (int i = 0; i < 72; i++) begin
            if (i % 6 == 0) begin
                d = xs();
                m_pm = d[0] & d[1];
                m_fm = d[2] & d[3];
                m_bp = d[4] ? {4'h0, d[9:5]} : 9'h000;
                apb(1'h1, cpm_pkg::CPM_PRIMARY_INTERRUPT_MASK_OFS, 32'(m_pm));
                apb(1'h1, cpm_pkg::CPM_FLTMASK_OFS, 32'(m_fm));
                apb(1'h1, cpm_pkg::CPM_BASE_PRIORITY_THRESHOLD_OFS, 32'(m_bp));
                apb(1'h0, cpm_pkg::CPM_BASE_PRIORITY_THRESHOLD_OFS, 32'h0);
                chk("bp_rd", 32'(m_bp), rd);
            end
            d = xs();
            d[8:6] = 3'h0;
            if (i % 6 < 2) d[17:9] = 9'h002 + 9'(i % 6);
            if (i % 6 == 2) d[17:13] = 5'h00;
            @(posedge ref_clk);
            cand <= d[17:0];
            cand_valid <= 1'h1;
            @(negedge ref_clk);
            chk("alw", alw(d), 32'(cand_allowed));
        end
        final_report();
    end
endmodule
`default_nettype wire
